// [src/isp_port.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - eeprom byte writes erase then write the target, no chip erase needed
// - chip erase sets all program and eeprom locations to all ones
// - data-in bits are sampled on each rising sck edge
// - data-out bits change on each falling sck edge
// - second enable byte echoes on data-out during the third byte
// - page write commits buffer to page chosen by 7 upper bits
// - eeprom byte write carries address and data; 3.6ms wait follows
// - eeprom page commit alters only the loaded locations
// - read instructions return addressed content in the fourth byte
// - erase is AC 80 00 00; enable is AC 53 00 00
// - page loads are 48 high, 40 low; 4D is accepted but has no effect
// - program reads are 28 high, 20 low with high and low address
// - eeprom C0 write, C1 load, C2 commit, A0 read, 10-bit address
// - fuse writes AC A0, A8, A4; lock write AC E0
// - fuse, lock, signature and calibration reads return fourth byte
// - program and erase rejected until programming enable executed
// - poll answer bit 0 is set while a write is pending
module isp_port #(
  parameter int unsigned PAGE_WAIT_CYC  = isp_pkg::PAGE_WAIT_CYC,
  parameter int unsigned EE_WAIT_CYC    = isp_pkg::EE_WAIT_CYC,
  parameter int unsigned ERASE_WAIT_CYC = isp_pkg::ERASE_WAIT_CYC,
  parameter int unsigned FUSE_WAIT_CYC  = isp_pkg::FUSE_WAIT_CYC
) (
  // core clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // serial link from the programmer
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // status
  output logic            write_pending_poll,
  output logic            prog_enabled,
  output logic [3:0]      clock_source_select_fuses
);

  localparam int FAW = isp_pkg::FLASH_AW;
  localparam int EAW = isp_pkg::EE_AW;
  localparam int POW = isp_pkg::PAGE_OFS_W;
  localparam int PNW = isp_pkg::PAGE_NUM_W;
  localparam int WW  = isp_pkg::WAIT_W;
  localparam int PG  = 1 << POW;

  logic                 link_rst_reg;
  logic [isp_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
  logic [31:0]          rx_reg;
  logic [31:0]          rx_next;
  logic [31:0]          frame_reg;
  logic [23:0]          hdr_reg;
  logic                 frame_tgl_reg;
  logic                 hdr_tgl_reg;
  logic [7:0]           tx_reg;
  logic [7:0]           tx_byte;
  logic                 miso_reg;
  logic                 rx_msb;
  logic                 frame_evt;
  logic                 hdr_evt;
  logic [7:0]           fb1, fb2, fb3, fb4;
  logic [7:0]           hb1, hb2, hb3;
  logic [15:0]          faddr;
  logic [15:0]          haddr;
  logic [PNW-1:0]       fpage;
  logic [EAW-1:0]       fee_addr;
  logic [POW-1:0]       fofs;
  logic [15:0]          flash_mem [1 << FAW];
  logic [7:0]           ee_mem    [1 << EAW];
  logic [15:0]          pbuf      [PG];
  logic [7:0]           ebuf      [PG];
  logic [PG-1:0]        eload_reg;
  logic [7:0]           fuse_lo_reg;
  logic [7:0]           fuse_hi_reg;
  logic [7:0]           fuse_ext_reg;
  logic [7:0]           lock_reg;
  logic [7:0]           rd_data_reg;
  logic                 prog_en_reg;
  isp_pkg::walk_e       op_reg;
  logic [FAW-1:0]       idx_reg;
  logic [FAW-1:0]       idx_last;
  logic [POW-1:0]       idx_ofs;
  logic [PNW-1:0]       page_reg;
  logic [EAW-1:0]       ee_wa;
  logic [7:0]           ee_old;
  logic [7:0]           ee_rd;
  logic [WW-1:0]        wait_reg;
  logic [WW-1:0]        wait_next;
  logic                 busy;
  logic                 accept;
  logic                 is_enable;
  logic                 is_erase;
  logic                 is_fuse;

  // link-side reset, held from the core reset
  always_ff @(posedge clk) begin
    link_rst_reg <= reset;
  end

  // receive shift on rising sck, msb first
  assign rx_next = {rx_reg[30:0], mosi};

  always_ff @(posedge sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      bit_cnt_reg   <= '0;
      rx_reg        <= '0;
      hdr_reg       <= '0;
      frame_reg     <= '0;
      hdr_tgl_reg   <= 1'b0;
      frame_tgl_reg <= 1'b0;
    end else begin
      rx_reg      <= rx_next;
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (bit_cnt_reg == isp_pkg::BIT_HDR_LAST) begin
        hdr_reg     <= rx_next[23:0];
        hdr_tgl_reg <= ~hdr_tgl_reg;
      end
      if (bit_cnt_reg == isp_pkg::BIT_FRAME_LAST) begin
        frame_reg     <= rx_next;
        frame_tgl_reg <= ~frame_tgl_reg;
      end
    end
  end

  // byte to send: read answer in byte four, else last byte heard
  always_comb begin
    if (bit_cnt_reg == isp_pkg::BIT_RESP_START) begin
      tx_byte = rd_data_reg;
    end else begin
      tx_byte = rx_reg[7:0];
    end
  end

  // transmit shift on falling sck
  always_ff @(negedge sck or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      tx_reg   <= '0;
      miso_reg <= 1'b0;
    end else if (bit_cnt_reg[2:0] == isp_pkg::BYTE_START) begin
      miso_reg <= tx_byte[7];
      tx_reg   <= {tx_byte[6:0], 1'b0};
    end else begin
      miso_reg <= tx_reg[7];
      tx_reg   <= {tx_reg[6:0], 1'b0};
    end
  end

  assign miso   = miso_reg;
  assign rx_msb = rx_reg[7];

  // link events into the core domain
  isp_sync_pulse u_frame_sync (
    .clk    (clk),
    .reset  (reset),
    .tgl_in (frame_tgl_reg),
    .pulse  (frame_evt)
  );

  isp_sync_pulse u_hdr_sync (
    .clk    (clk),
    .reset  (reset),
    .tgl_in (hdr_tgl_reg),
    .pulse  (hdr_evt)
  );

  // frame and header fields
  assign {fb1, fb2, fb3, fb4} = frame_reg;
  assign {hb1, hb2, hb3}      = hdr_reg;
  assign faddr    = {fb2, fb3};
  assign haddr    = {hb2, hb3};
  assign fpage    = faddr[POW+PNW-1:POW];
  assign fee_addr = faddr[EAW-1:0];
  assign fofs     = fb3[POW-1:0];

  // instruction classes
  assign is_enable = (fb1 == isp_pkg::CMD_AC_GROUP)
                  && (fb2 == isp_pkg::SUB_ENABLE);
  assign is_erase  = (fb1 == isp_pkg::CMD_AC_GROUP)
                  && (fb2 == isp_pkg::SUB_ERASE)
                  && (fb3 == isp_pkg::BYTE_ZERO)
                  && (fb4 == isp_pkg::BYTE_ZERO);
  assign is_fuse   = (fb1 == isp_pkg::CMD_AC_GROUP)
                  && ((fb2 == isp_pkg::SUB_FUSE_LO)
                   || (fb2 == isp_pkg::SUB_FUSE_HI)
                   || (fb2 == isp_pkg::SUB_FUSE_EXT)
                   || (fb2 == isp_pkg::SUB_LOCK));

  assign busy   = (wait_reg != '0) || (op_reg != isp_pkg::OP_IDLE);
  assign accept = frame_evt && prog_en_reg && !busy;

  // programming enable latch
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_en_reg <= 1'b0;
    end else if (frame_evt && is_enable) begin
      prog_en_reg <= 1'b1;
    end
  end

  // last index of the current walk
  assign idx_last = (op_reg == isp_pkg::OP_ERASE) ? '1
                  : {{(FAW-POW){1'b0}}, {POW{1'b1}}};
  assign idx_ofs  = idx_reg[POW-1:0];

  // background walk for erase and page commits
  always_ff @(posedge clk) begin
    if (reset) begin
      op_reg   <= isp_pkg::OP_IDLE;
      idx_reg  <= '0;
      page_reg <= '0;
    end else if (op_reg != isp_pkg::OP_IDLE) begin
      idx_reg <= idx_reg + 1'b1;
      if (idx_reg == idx_last) begin
        op_reg <= isp_pkg::OP_IDLE;
      end
    end else if (accept) begin
      idx_reg  <= '0;
      page_reg <= fpage;
      if (is_erase) begin
        op_reg <= isp_pkg::OP_ERASE;
      end else if (fb1 == isp_pkg::CMD_WR_PAGE) begin
        op_reg <= isp_pkg::OP_PAGE;
      end else if (fb1 == isp_pkg::CMD_EE_PAGE) begin
        op_reg <= isp_pkg::OP_EEPAGE;
      end
    end
  end

  // wait time loaded by each self-timed write
  always_comb begin
    wait_next = '0;
    if (is_erase) begin
      wait_next = WW'(ERASE_WAIT_CYC);
    end else if (is_fuse) begin
      wait_next = WW'(FUSE_WAIT_CYC);
    end else if (fb1 == isp_pkg::CMD_WR_PAGE) begin
      wait_next = WW'(PAGE_WAIT_CYC);
    end else if ((fb1 == isp_pkg::CMD_EE_WR)
              || (fb1 == isp_pkg::CMD_EE_PAGE)) begin
      wait_next = WW'(EE_WAIT_CYC);
    end
  end

  // pending-write timer
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_reg <= '0;
    end else if (accept) begin
      wait_reg <= wait_next;
    end else if (wait_reg != '0) begin
      wait_reg <= wait_reg - 1'b1;
    end
  end

  // program memory array
  always_ff @(posedge clk) begin
    if (op_reg == isp_pkg::OP_ERASE) begin
      flash_mem[idx_reg] <= isp_pkg::ERASED_WORD;
    end else if (op_reg == isp_pkg::OP_PAGE) begin
      flash_mem[{page_reg, idx_ofs}] <= pbuf[idx_ofs];
    end
  end

  // program page buffer, refilled with ones once committed
  always_ff @(posedge clk) begin
    if (op_reg == isp_pkg::OP_PAGE) begin
      pbuf[idx_ofs] <= isp_pkg::ERASED_WORD;
    end else if (accept && (fb1 == isp_pkg::CMD_LOAD_LO)) begin
      pbuf[fofs][7:0] <= fb4;
    end else if (accept && (fb1 == isp_pkg::CMD_LOAD_HI)) begin
      pbuf[fofs][15:8] <= fb4;
    end
  end

  // eeprom array: erase, page commit, byte write
  always_ff @(posedge clk) begin
    if ((op_reg == isp_pkg::OP_ERASE)
        && (idx_reg[FAW-1:EAW] == '0)) begin
      ee_mem[idx_reg[EAW-1:0]] <= isp_pkg::ERASED_BYTE;
    end else if ((op_reg == isp_pkg::OP_EEPAGE) && eload_reg[idx_ofs]) begin
      ee_mem[ee_wa] <= ebuf[idx_ofs];
    end else if (accept && (fb1 == isp_pkg::CMD_EE_WR)) begin
      ee_mem[fee_addr] <= fb4;
    end
  end

  assign ee_wa  = {page_reg[EAW-POW-1:0], idx_ofs};
  assign ee_old = ee_mem[ee_wa];

  // eeprom page buffer and its loaded marks
  always_ff @(posedge clk) begin
    if (reset) begin
      eload_reg <= '0;
    end else if (op_reg == isp_pkg::OP_EEPAGE) begin
      eload_reg[idx_ofs] <= 1'b0;
    end else if (accept && (fb1 == isp_pkg::CMD_EE_LOAD)) begin
      eload_reg[fee_addr[POW-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (accept && (fb1 == isp_pkg::CMD_EE_LOAD)) begin
      ebuf[fee_addr[POW-1:0]] <= fb4;
    end
  end

  // fuse and lock bytes, lock cleared by erase
  always_ff @(posedge clk) begin
    if (reset) begin
      fuse_lo_reg  <= isp_pkg::FUSE_LO_INIT;
      fuse_hi_reg  <= isp_pkg::FUSE_HI_INIT;
      fuse_ext_reg <= isp_pkg::FUSE_EXT_INIT;
      lock_reg     <= isp_pkg::LOCK_INIT;
    end else if (accept && is_erase) begin
      lock_reg <= isp_pkg::ERASED_BYTE;
    end else if (accept && is_fuse) begin
      if (fb2 == isp_pkg::SUB_FUSE_LO) begin
        fuse_lo_reg <= fb4;
      end else if (fb2 == isp_pkg::SUB_FUSE_HI) begin
        fuse_hi_reg <= fb4;
      end else if (fb2 == isp_pkg::SUB_FUSE_EXT) begin
        fuse_ext_reg <= fb4;
      end else begin
        lock_reg <= fb4;
      end
    end
  end

  assign ee_rd = ee_mem[haddr[EAW-1:0]];

  // answer byte, prepared once three bytes are in
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_reg <= '0;
    end else if (hdr_evt) begin
      if (hb1 == isp_pkg::CMD_RD_LO) begin
        rd_data_reg <= flash_mem[haddr[FAW-1:0]][7:0];
      end else if (hb1 == isp_pkg::CMD_RD_HI) begin
        rd_data_reg <= flash_mem[haddr[FAW-1:0]][15:8];
      end else if (hb1 == isp_pkg::CMD_EE_RD) begin
        rd_data_reg <= ee_rd;
      end else if (hb1 == isp_pkg::CMD_POLL) begin
        rd_data_reg <= {7'h00, busy};
      end else if (hb1 == isp_pkg::CMD_RD_FUSE) begin
        rd_data_reg <= (hb2 == isp_pkg::SUB_HIGH_SEL)
                     ? fuse_ext_reg : fuse_lo_reg;
      end else if (hb1 == isp_pkg::CMD_RD_LOCKH) begin
        rd_data_reg <= (hb2 == isp_pkg::SUB_HIGH_SEL)
                     ? fuse_hi_reg : lock_reg;
      end else if (hb1 == isp_pkg::CMD_RD_SIG) begin
        if (hb3[1:0] == 2'h0) begin
          rd_data_reg <= isp_pkg::SIG_BYTE0;
        end else if (hb3[1:0] == 2'h1) begin
          rd_data_reg <= isp_pkg::SIG_BYTE1;
        end else if (hb3[1:0] == 2'h2) begin
          rd_data_reg <= isp_pkg::SIG_BYTE2;
        end else begin
          rd_data_reg <= isp_pkg::BYTE_ZERO;
        end
      end else if (hb1 == isp_pkg::CMD_RD_CAL) begin
        rd_data_reg <= isp_pkg::CAL_INIT;
      end else begin
        rd_data_reg <= hb3;
      end
    end
  end

  // registered status outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      write_pending_poll        <= 1'b0;
      prog_enabled              <= 1'b0;
      clock_source_select_fuses <= isp_pkg::FUSE_LO_INIT[3:0];
    end else begin
      write_pending_poll        <= busy;
      prog_enabled              <= prog_en_reg;
      clock_source_select_fuses <= fuse_lo_reg[3:0];
    end
  end

  // checks
  a_echo_second: assert property (@(negedge sck) disable iff (link_rst_reg)
    (bit_cnt_reg == isp_pkg::BIT_ECHO_START) |=> (miso_reg == $past(rx_msb)))
    else $error("second byte not echoed");
  a_locked_reject: assert property (@(posedge clk) disable iff (reset)
    (frame_evt && !prog_en_reg && !busy) |=> !busy)
    else $error("write ran before enable");
  a_erase_start: assert property (@(posedge clk) disable iff (reset)
    (accept && is_erase) |=> (op_reg == isp_pkg::OP_ERASE)
      && (wait_reg == WW'(ERASE_WAIT_CYC)))
    else $error("erase not started");
  a_erase_fill: assert property (@(posedge clk) disable iff (reset)
    (op_reg == isp_pkg::OP_ERASE)
      |=> (flash_mem[$past(idx_reg)] == isp_pkg::ERASED_WORD))
    else $error("erase left a word");
  a_page_select: assert property (@(posedge clk) disable iff (reset)
    (accept && (fb1 == isp_pkg::CMD_WR_PAGE))
      |=> (op_reg == isp_pkg::OP_PAGE) && (page_reg == $past(fpage)))
    else $error("wrong page committed");
  a_ee_byte: assert property (@(posedge clk) disable iff (reset)
    (accept && (fb1 == isp_pkg::CMD_EE_WR))
      |=> (ee_mem[$past(fee_addr)] == $past(fb4)) ##1 busy)
    else $error("eeprom byte not written");
  a_ee_keep: assert property (@(posedge clk) disable iff (reset)
    ((op_reg == isp_pkg::OP_EEPAGE) && !eload_reg[idx_ofs])
      |=> (ee_mem[$past(ee_wa)] === $past(ee_old)))
    else $error("unloaded eeprom byte changed");
  a_poll_bit: assert property (@(posedge clk) disable iff (reset)
    (hdr_evt && (hb1 == isp_pkg::CMD_POLL))
      |=> (rd_data_reg[0] == $past(busy)))
    else $error("poll bit wrong");
  a_read_ee: assert property (@(posedge clk) disable iff (reset)
    (hdr_evt && (hb1 == isp_pkg::CMD_EE_RD)) |=> (rd_data_reg == $past(ee_rd)))
    else $error("eeprom read wrong");
  a_decode_late: assert property (@(posedge clk) disable iff (reset)
    $rose(busy) |-> $past(frame_evt))
    else $error("write began mid frame");
  a_fuse_write: assert property (@(posedge clk) disable iff (reset)
    (accept && is_fuse && (fb2 == isp_pkg::SUB_FUSE_LO))
      |=> (fuse_lo_reg == $past(fb4)) && busy)
    else $error("low fuse not written");

endmodule : isp_port
`default_nettype wire

// [include/isp_pkg.sv]
`default_nettype none
package isp_pkg;

  // clock and minimum wait times
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PAGE_WAIT_NS   = 4_500_000; // page_write_wait
  localparam int EE_WAIT_NS     = 3_600_000; // eeprom_write_wait
  localparam int ERASE_WAIT_NS  = 9_000_000; // full_erase_wait
  localparam int FUSE_WAIT_NS   = 4_500_000; // fuse_write_wait
  localparam int PAGE_WAIT_CYC  =
    (PAGE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_WAIT_CYC    =
    (EE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_WAIT_CYC =
    (ERASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FUSE_WAIT_CYC  =
    (FUSE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W         = 20;

  // memory geometry
  localparam int FLASH_AW   = 13;
  localparam int EE_AW      = 10;
  localparam int PAGE_OFS_W = 6;
  localparam int PAGE_NUM_W = 7;
  localparam int BIT_CNT_W  = 5;

  // bit positions within a 32-bit frame
  localparam logic [4:0] BIT_HDR_LAST   = 5'h17;
  localparam logic [4:0] BIT_FRAME_LAST = 5'h1F;
  localparam logic [4:0] BIT_ECHO_START = 5'h10;
  localparam logic [4:0] BIT_RESP_START = 5'h18;
  localparam logic [2:0] BYTE_START     = 3'h0;

  // first and second instruction bytes
  localparam logic [7:0] CMD_AC_GROUP = 8'hAC;
  localparam logic [7:0] SUB_ENABLE   = 8'h53;
  localparam logic [7:0] SUB_ERASE    = 8'h80;
  localparam logic [7:0] SUB_FUSE_LO  = 8'hA0;
  localparam logic [7:0] SUB_FUSE_HI  = 8'hA8;
  localparam logic [7:0] SUB_FUSE_EXT = 8'hA4;
  localparam logic [7:0] SUB_LOCK     = 8'hE0;
  localparam logic [7:0] SUB_HIGH_SEL = 8'h08;
  localparam logic [7:0] CMD_POLL     = 8'hF0;
  localparam logic [7:0] CMD_EXT_ADDR = 8'h4D;
  localparam logic [7:0] CMD_LOAD_HI  = 8'h48;
  localparam logic [7:0] CMD_LOAD_LO  = 8'h40;
  localparam logic [7:0] CMD_WR_PAGE  = 8'h4C;
  localparam logic [7:0] CMD_RD_HI    = 8'h28;
  localparam logic [7:0] CMD_RD_LO    = 8'h20;
  localparam logic [7:0] CMD_EE_WR    = 8'hC0;
  localparam logic [7:0] CMD_EE_LOAD  = 8'hC1;
  localparam logic [7:0] CMD_EE_PAGE  = 8'hC2;
  localparam logic [7:0] CMD_EE_RD    = 8'hA0;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h50;
  localparam logic [7:0] CMD_RD_LOCKH = 8'h58;
  localparam logic [7:0] CMD_RD_SIG   = 8'h30;
  localparam logic [7:0] CMD_RD_CAL   = 8'h38;

  // data values
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0]  FUSE_LO_INIT  = 8'hFF;
  localparam logic [7:0]  FUSE_HI_INIT  = 8'hFF;
  localparam logic [7:0]  FUSE_EXT_INIT = 8'hFF;
  localparam logic [7:0]  LOCK_INIT     = 8'hFF;
  localparam logic [7:0]  CAL_INIT      = 8'h80;
  // identity bytes, values arbitrary
  localparam logic [7:0]  SIG_BYTE0 = 8'h5A;
  localparam logic [7:0]  SIG_BYTE1 = 8'hA5;
  localparam logic [7:0]  SIG_BYTE2 = 8'h3C;

  // background walk through memory
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_PAGE,
    OP_EEPAGE
  } walk_e;

endpackage : isp_pkg
`default_nettype wire

// [src/isp_sync_pulse.sv]
`timescale 1ns/1ps
`default_nettype none
module isp_sync_pulse (
  // core clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // toggle from the link domain
  input  wire logic tgl_in,
  // one-cycle pulse per toggle change
  output logic      pulse
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // two-stage synchroniser plus history
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= tgl_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edge of the synchronised toggle
  assign pulse = sync_reg ^ last_reg;

endmodule : isp_sync_pulse
`default_nettype wire

// [test/isp_programmer.sv]
`timescale 1ns/1ps
`default_nettype none
module isp_programmer (
  // serial link to the port
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  localparam int PHASE_NS = 48; // four 12 ns link ticks per phase

  // link idles with sck held low
  initial begin
    sck  = 1'b0;
    mosi = 1'b0;
  end

  // one whole frame, msb first, answer sampled on rising sck
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #(PHASE_NS);
      sck = 1'b1;
      rx[i] = miso;
      // longer high phase lets the read answer cross over
      #(i == 8 ? 2 * PHASE_NS : PHASE_NS);
      sck = 1'b0;
    end
    mosi = ~mosi; // released line must not keep its last value
  endtask : xfer
endmodule : isp_programmer
`default_nettype wire

// [test/serial_isp_programming_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_isp_programming_port_bench;
  logic        clk;
  logic        reset;
  logic        sck;
  logic        mosi;
  logic        miso;
  logic        write_pending_poll;
  logic        prog_enabled;
  logic [3:0]  clock_source_select_fuses;
  logic [31:0] r;
  int          errors;
  int          checks;

  // device under test with short self-timed waits
  isp_port #(
    .PAGE_WAIT_CYC (2000),
    .EE_WAIT_CYC   (2000),
    .ERASE_WAIT_CYC(2000),
    .FUSE_WAIT_CYC (2000)
  ) i_isp_port (
    .clk                      (clk),
    .reset                    (reset),
    .sck                      (sck),
    .mosi                     (mosi),
    .miso                     (miso),
    .write_pending_poll       (write_pending_poll),
    .prog_enabled             (prog_enabled),
    .clock_source_select_fuses(clock_source_select_fuses)
  );

  // programmer on the far side of the link
  isp_programmer i_isp_programmer (
    .sck (sck),
    .mosi(mosi),
    .miso(miso)
  );

  // core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // one frame, then a few core cycles for it to execute
  task automatic send(input logic [31:0] f);
    i_isp_programmer.xfer(f, r);
    repeat (5) @(posedge clk);
    #1;
  endtask : send

  task automatic rd(input logic [31:0] f, input logic [7:0] exp);
    send(f);
    chk(r[7:0], exp);
  endtask : rd

  // bounded wait for the self-timed write to finish
  task automatic settle;
    int n;
    n = 0;
    while (write_pending_poll !== 1'b0 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, write_pending_poll}, 8'h00);
  endtask : settle

  task automatic t_refuse;
    chk({4'h0, clock_source_select_fuses}, 8'h0F);
    send(32'hC0_01_05_AB);
    chk({7'h00, write_pending_poll}, 8'h00);
    chk({7'h00, prog_enabled}, 8'h00);
    $display("refuse test done");
  endtask : t_refuse

  task automatic t_enable;
    send(32'hAC_53_00_00);
    chk(r[15:8], isp_pkg::SUB_ENABLE);
    chk({7'h00, prog_enabled}, 8'h01);
    $display("enable test done");
  endtask : t_enable

  task automatic t_eeprom;
    send(32'hC0_01_05_3C);
    chk({7'h00, write_pending_poll}, 8'h01);
    rd(32'hF0_00_00_00, 8'h01);
    settle;
    rd(32'hF0_00_00_00, 8'h00);
    rd(32'hA0_01_05_00, 8'h3C);
    send(32'hC0_01_05_5A);
    settle;
    rd(32'hA0_01_05_00, 8'h5A);
    $display("eeprom byte test done");
  endtask : t_eeprom

  task automatic t_eepage;
    send(32'hC1_00_01_11);
    send(32'hC1_00_3F_22);
    send(32'hC2_01_00_00);
    settle;
    rd(32'hA0_01_01_00, 8'h11);
    rd(32'hA0_01_3F_00, 8'h22);
    rd(32'hA0_01_05_00, 8'h5A);
    $display("eeprom page test done");
  endtask : t_eepage

  task automatic t_flash;
    send(32'h40_00_02_34);
    send(32'h48_00_02_12);
    send(32'h4D_00_00_00);
    send(32'h4C_00_C0_00);
    settle;
    rd(32'h20_00_C2_00, 8'h34);
    rd(32'h28_00_C2_00, 8'h12);
    $display("flash page test done");
  endtask : t_flash

  task automatic t_fuses;
    logic [7:0]  sub [4];
    logic [15:0] rdc [4];
    logic [7:0]  dat [4];
    sub = '{8'hA0, 8'hA8, 8'hA4, 8'hE0};
    rdc = '{16'h5000, 16'h5808, 16'h5008, 16'h5800};
    dat = '{8'hF2, 8'hD9, 8'hFD, 8'hFC};
    for (int k = 0; k < 4; k++) begin
      send({8'hAC, sub[k], 8'h00, dat[k]});
      settle;
      rd({rdc[k], 16'h0000}, dat[k]);
    end
    chk({4'h0, clock_source_select_fuses}, 8'h02);
    rd(32'h30_00_00_00, isp_pkg::SIG_BYTE0);
    rd(32'h30_00_02_00, isp_pkg::SIG_BYTE2);
    rd(32'h38_00_00_00, isp_pkg::CAL_INIT);
    $display("fuse test done");
  endtask : t_fuses

  task automatic t_erase;
    send(32'hAC_80_00_00);
    settle;
    rd(32'hA0_01_05_00, 8'hFF);
    rd(32'h20_00_C2_00, 8'hFF);
    rd(32'h58_00_00_00, 8'hFF);
    $display("erase test done");
  endtask : t_erase

  // main sequence
  initial begin
    errors = 0;
    checks = 0;
    reset  = 1'b1;
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    // shortened power-up wait before the first frame
    repeat (5) @(posedge clk);
    #1;
    t_refuse;
    t_enable;
    t_eeprom;
    t_eepage;
    t_flash;
    t_fuses;
    t_erase;
    give_verdict;
  end

  // watchdog well beyond the expected run time
  initial begin
    #800_000;
    errors++;
    give_verdict;
  end
endmodule : serial_isp_programming_port_bench
`default_nettype wire
